// ==== logic/ieack_pkg.sv ====
// constants, types and register map of the interrupt edge and acknowledge block
package ieack_pkg;

  localparam int          N_EXT          = 8;
  localparam int          SEL_W          = 3;
  localparam int          ADDR_W         = 20;

  // register addresses in the special function register space
  localparam logic [19:0] ADDR_RISE_EN   = 20'hFFF38;
  localparam logic [19:0] ADDR_FALL_EN   = 20'hFFF39;
  localparam logic [19:0] ADDR_STATUS    = 20'hFFFFA;

  // values after reset
  localparam logic [7:0]  RISE_EN_RST    = 8'h00;
  localparam logic [7:0]  FALL_EN_RST    = 8'h00;
  localparam logic [7:0]  STATUS_RST     = 8'h06;
  localparam logic [7:0]  REQ_RST        = 8'h00;

  // status word field positions
  localparam int          SW_IE          = 7;
  localparam int          SW_IN_SERVICE_LEVEL_HI        = 2;
  localparam int          SW_IN_SERVICE_LEVEL_LO        = 1;

  // vector table
  localparam logic [19:0] VEC_SOFT       = 20'h0007E;
  localparam logic [19:0] VEC_EXT_BASE   = 20'h00008;
  localparam int          VEC_STEP_SHIFT = 1;

  // priority levels
  localparam logic [1:0]  LEVEL_TOP      = 2'h0;
  localparam logic [1:0]  LEVEL_BOTTOM   = 2'h3;

  // acknowledge latency, in cpu clocks, and the cycle counts derived from it
  localparam int          LAT_MIN_CLK    = 9;
  localparam int          LAT_MAX_CLK    = 16;
  localparam int          CYC_PER_CLK    = 1;
  localparam int          LAT_MIN_CYC    = LAT_MIN_CLK * CYC_PER_CLK;
  localparam int          LAT_MAX_CYC    = LAT_MAX_CLK * CYC_PER_CLK;
  localparam int          LAT_W          = 5;
  localparam logic [4:0]  LAT_MIN_LAST   = 5'(LAT_MIN_CYC - 1);
  localparam logic [4:0]  LAT_MAX_LAST   = 5'(LAT_MAX_CYC - 1);

  typedef enum {
    ST_IDLE,
    ST_PUSH_SW,
    ST_PUSH_PC,
    ST_VECTOR
  } ieack_state_t;

endpackage

// ==== logic/ieack_edge_if.sv ====
// carrier between the edge detector and the acknowledge core
`timescale 1ns/100ps
interface ieack_edge_if;
  import ieack_pkg::*;

  logic [N_EXT-1:0] rise_en;
  logic [N_EXT-1:0] fall_en;
  logic [N_EXT-1:0] edge_hit;

  modport detect (input rise_en, input fall_en, output edge_hit);
  modport core   (output rise_en, output fall_en, input edge_hit);
endinterface

// ==== logic/ieack_edge.sv ====
// per-pin synchroniser and valid edge selection
`timescale 1ns/100ps
module ieack_edge
  import ieack_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pins
  input  wire logic [N_EXT-1:0] ext_irq_input,
  // core side
  ieack_edge_if.detect          eif
);

  logic [N_EXT-1:0] meta_q;
  logic [N_EXT-1:0] sync_q;
  logic [N_EXT-1:0] prev_q;

  for (genvar i = 0; i < N_EXT; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= ext_irq_input[i];
        sync_q[i] <= meta_q[i];
        prev_q[i] <= sync_q[i];
      end
    end
    // enables gate the hit in the same cycle, so clearing both bits before
    // turning the pin into an output suppresses any edge it makes [RL4]
    assign eif.edge_hit[i] = (eif.rise_en[i] & sync_q[i] & ~prev_q[i])   // [RL1] [RL23]
                           | (eif.fall_en[i] & ~sync_q[i] & prev_q[i]);  // [RL1] [RL23]
  end

  edge_off_a: assert property (@(posedge clk) disable iff (reset) // [RL1]
    (eif.rise_en == 8'h00 && eif.fall_en == 8'h00) |-> eif.edge_hit == 8'h00)
    else $error("edge seen with detection disabled");

endmodule

// ==== logic/ieack_top.sv ====
// interrupt edge selection, arbitration and acknowledge sequencing
//
// Contract
// RL1: bit pair picks none, falling, rising, both
// RL2: reset clears both edge enable registers
// RL3: edge enables take bit and byte writes
// RL4: software disables edges before making pin output
// RL5: status word holds enable, level; resets 06H
// RL6: eligible only with flag set, mask clear
// RL7: need global enable; lower levels held off
// RL8: acknowledge latency from 9 to 16 clocks
// RL9: upper bound waived while running from RAM
// RL10: best level wins, then default priority
// RL11: blocked requests stay pending until acceptable
// RL12: push status then pc, clear enable
// RL13: nonzero level minus one into in-service flags
// RL14: load pc from request's vector entry
// RL15: returns and pop restore; push saves status
// RL16: status byte, bit, set/clear enable access
// RL17: break interrupts regardless of enable, masks
// RL18: break pushes, clears enable, vectors 0007EH
// RL19: soft handler returns only by soft return
// RL20: pair 00 highest level through 11 lowest
// RL21: mask 0 enables, 1 disables servicing
// RL22: in-service 11 admits all, lower blocks more
// RL23: synchronised enabled edge sets request flag
`timescale 1ns/100ps
module ieack_top
  import ieack_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // external interrupt pins
  input  wire logic [N_EXT-1:0]  ext_irq_input,
  // request flags, masks and priorities
  input  wire logic [N_EXT-1:0]  mask_flag,
  input  wire logic [N_EXT-1:0]  priority_bit_lo,
  input  wire logic [N_EXT-1:0]  priority_bit_hi,
  input  wire logic [N_EXT-1:0]  request_clear,
  output logic      [N_EXT-1:0]  request_flag,
  // memory manipulation access
  input  wire logic [ADDR_W-1:0] sfr_addr,
  input  wire logic              sfr_rd,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_bit_op,
  input  wire logic [SEL_W-1:0]  sfr_bit_sel,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // instruction sequencer
  input  wire logic              instr_boundary,
  input  wire logic              instr_from_ram,
  input  wire logic              break_instruction,
  input  wire logic              set_enable_instr,
  input  wire logic              clear_enable_instr,
  input  wire logic              push_status_instr,
  input  wire logic              pop_status_instr,
  input  wire logic              maskable_return_instr,
  input  wire logic              soft_irq_return_instr,
  input  wire logic [7:0]        stack_pop_data,
  input  wire logic [ADDR_W-1:0] cpu_pc,
  // stack and vector outputs
  output logic                   irq_busy,
  output logic                   stack_push,
  output logic                   stack_push_is_pc,
  output logic      [ADDR_W-1:0] stack_push_data,
  output logic                   vector_load,
  output logic      [ADDR_W-1:0] vector_addr,
  output logic      [7:0]        status_word,
  output logic                   global_irq_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  ieack_edge_if eif ();

  ieack_state_t      state_q;
  logic [7:0]        rise_en_q;
  logic [7:0]        fall_en_q;
  logic [7:0]        sw_q;
  logic [N_EXT-1:0]  req_q;
  logic              soft_pend_q;
  logic [LAT_W-1:0]  pend_cnt_q;
  logic [ADDR_W-1:0] pc_hold_q;
  logic [ADDR_W-1:0] vec_q;
  logic [7:0]        sw_saved_q;
  logic [7:0]        rdata_q;
  logic              push_q;
  logic              push_pc_q;
  logic [ADDR_W-1:0] push_data_q;
  logic              vload_q;
  logic [ADDR_W-1:0] vaddr_q;

  logic [N_EXT-1:0]  elig;
  logic [1:0]        lvl [N_EXT];
  logic              win_any;
  logic [SEL_W-1:0]  win_idx;
  logic [1:0]        win_lvl;
  logic [1:0]        isp;
  logic              cand_ok;
  logic              acc_mask;
  logic              acc_soft;
  logic              acc_any;
  logic              late;
  logic [N_EXT-1:0]  acc_clr;
  logic              hit_rise;
  logic              hit_fall;
  logic              hit_sw;

  ieack_edge u_edge (
    .clk           (clk),
    .reset         (reset),
    .ext_irq_input (ext_irq_input),
    .eif           (eif.detect)
  );

  assign eif.rise_en = rise_en_q;
  assign eif.fall_en = fall_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // register access

  assign hit_rise = sfr_wr && (sfr_addr == ADDR_RISE_EN);
  assign hit_fall = sfr_wr && (sfr_addr == ADDR_FALL_EN);
  assign hit_sw   = sfr_wr && (sfr_addr == ADDR_STATUS);

  always_ff @(posedge clk) begin
    if (reset) begin
      rise_en_q <= RISE_EN_RST;                          // [RL2]
      fall_en_q <= FALL_EN_RST;                          // [RL2]
    end else begin
      if (hit_rise && sfr_bit_op) begin
        rise_en_q[sfr_bit_sel] <= sfr_wdata[0];          // [RL3]
      end else if (hit_rise) begin
        rise_en_q <= sfr_wdata;                          // [RL3]
      end
      if (hit_fall && sfr_bit_op) begin
        fall_en_q[sfr_bit_sel] <= sfr_wdata[0];          // [RL3]
      end else if (hit_fall) begin
        fall_en_q <= sfr_wdata;                          // [RL3]
      end
    end
  end

  // unmapped reads answer zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        ADDR_RISE_EN: rdata_q <= rise_en_q;
        ADDR_FALL_EN: rdata_q <= fall_en_q;
        ADDR_STATUS:  rdata_q <= sw_q;
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags and arbitration

  // an edge in the clearing cycle wins, so no request is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      req_q <= REQ_RST;
    end else begin
      req_q <= (req_q & ~(request_clear | acc_clr)) | eif.edge_hit;  // [RL23] [RL11]
    end
  end

  assign isp = {sw_q[SW_IN_SERVICE_LEVEL_HI], sw_q[SW_IN_SERVICE_LEVEL_LO]};

  for (genvar i = 0; i < N_EXT; i++) begin : g_src
    assign lvl[i]  = {priority_bit_hi[i], priority_bit_lo[i]};        // [RL20]
    // 11 in service admits every level; smaller values shut out more
    assign elig[i] = req_q[i] && !mask_flag[i] && (lvl[i] <= isp);   // [RL6] [RL21] [RL22]
    assign acc_clr[i] = acc_mask && (win_idx == SEL_W'(i));
  end

  // scanning downward with <= lets the lower index take a tied level
  always_comb begin
    win_any = 1'b0;
    win_idx = '0;
    win_lvl = LEVEL_BOTTOM;
    for (int i = N_EXT - 1; i >= 0; i--) begin
      if (elig[i] && (!win_any || lvl[i] <= win_lvl)) begin     // [RL10]
        win_any = 1'b1;
        win_idx = SEL_W'(i);
        win_lvl = lvl[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acceptance timing

  assign cand_ok = win_any && sw_q[SW_IE] && !soft_pend_q
                && (state_q == ST_IDLE) && !break_instruction;      // [RL7] [RL11]

  // code fetched from ram may stretch past the upper bound
  assign late = (pend_cnt_q >= LAT_MAX_LAST) && !instr_from_ram;  // [RL9]

  assign acc_mask = cand_ok && (pend_cnt_q >= LAT_MIN_LAST)
                 && (instr_boundary || late);                    // [RL8]
  assign acc_soft = (state_q == ST_IDLE)
                 && (break_instruction || soft_pend_q);           // [RL17]
  assign acc_any  = acc_mask || acc_soft;

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_cnt_q <= '0;
    end else if (!cand_ok || acc_mask) begin
      pend_cnt_q <= '0;
    end else if (pend_cnt_q != LAT_MAX_LAST) begin
      pend_cnt_q <= pend_cnt_q + LAT_W'(1);                       // [RL8]
    end
  end

  // a break that lands while a vectoring is running waits for idle
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_pend_q <= 1'b0;
    end else if (break_instruction && state_q != ST_IDLE) begin
      soft_pend_q <= 1'b1;
    end else if (acc_soft) begin
      soft_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_q <= STATUS_RST;                                         // [RL5]
    end else if (acc_soft) begin
      sw_q[SW_IE] <= 1'b0;                                        // [RL18]
    end else if (acc_mask) begin
      sw_q[SW_IE] <= 1'b0;                                        // [RL12]
      if (win_lvl != LEVEL_TOP) begin
        {sw_q[SW_IN_SERVICE_LEVEL_HI], sw_q[SW_IN_SERVICE_LEVEL_LO]} <= win_lvl - 2'd1;         // [RL13]
      end else begin
        {sw_q[SW_IN_SERVICE_LEVEL_HI], sw_q[SW_IN_SERVICE_LEVEL_LO]} <= LEVEL_TOP;
      end
    end else if (pop_status_instr || maskable_return_instr || soft_irq_return_instr) begin
      sw_q <= stack_pop_data;                                     // [RL15]
    end else if (set_enable_instr) begin
      sw_q[SW_IE] <= 1'b1;                                        // [RL16]
    end else if (clear_enable_instr) begin
      sw_q[SW_IE] <= 1'b0;                                        // [RL16]
    end else if (hit_sw && sfr_bit_op) begin
      sw_q[sfr_bit_sel] <= sfr_wdata[0];                          // [RL16]
    end else if (hit_sw) begin
      sw_q <= sfr_wdata;                                          // [RL16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vectoring sequence

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ST_IDLE;
      sw_saved_q <= 8'h00;
      pc_hold_q  <= '0;
      vec_q      <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (acc_any) begin
            state_q    <= ST_PUSH_SW;
            sw_saved_q <= sw_q;                                   // [RL12]
            pc_hold_q  <= cpu_pc;
            vec_q      <= acc_soft ? VEC_SOFT                     // [RL18]
                        : VEC_EXT_BASE
                          + (ADDR_W'(win_idx) << VEC_STEP_SHIFT); // [RL14]
          end
        end
        ST_PUSH_SW: state_q <= ST_PUSH_PC;
        ST_PUSH_PC: state_q <= ST_VECTOR;
        ST_VECTOR:  state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  // outputs registered one cycle behind the sequence so data comes from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      push_q      <= 1'b0;
      push_pc_q   <= 1'b0;
      push_data_q <= '0;
      vload_q     <= 1'b0;
      vaddr_q     <= '0;
    end else begin
      push_q    <= 1'b0;
      push_pc_q <= 1'b0;
      vload_q   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (!acc_any && push_status_instr) begin
            push_q      <= 1'b1;                                  // [RL15]
            push_data_q <= ADDR_W'(sw_q);
          end
        end
        ST_PUSH_SW: begin
          push_q      <= 1'b1;                                    // [RL12]
          push_data_q <= ADDR_W'(sw_saved_q);
        end
        ST_PUSH_PC: begin
          push_q      <= 1'b1;                                    // [RL12]
          push_pc_q   <= 1'b1;
          push_data_q <= pc_hold_q;
        end
        ST_VECTOR: begin
          vload_q <= 1'b1;                                        // [RL14]
          vaddr_q <= vec_q;
        end
        default: begin
          push_q <= 1'b0;
        end
      endcase
    end
  end

  assign request_flag      = req_q;
  assign sfr_rdata         = rdata_q;
  assign irq_busy          = (state_q != ST_IDLE);
  assign stack_push        = push_q;
  assign stack_push_is_pc  = push_pc_q;
  assign stack_push_data   = push_data_q;
  assign vector_load       = vload_q;
  assign vector_addr       = vaddr_q;
  assign status_word       = sw_q;
  assign global_irq_enable = sw_q[SW_IE];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  reset_values_a: assert property (@(posedge clk) // [RL5]
    $past(reset) |-> (sw_q == STATUS_RST && rise_en_q == 8'h00 && fall_en_q == 8'h00))
    else $error("registers not at reset values");

  mask_gate_a: assert property (@(posedge clk) disable iff (reset) // [RL6]
    acc_mask |-> (req_q[win_idx] && !mask_flag[win_idx]))
    else $error("request accepted without flag or while masked");

  enable_gate_a: assert property (@(posedge clk) disable iff (reset) // [RL7]
    acc_mask |-> (sw_q[SW_IE] && win_lvl <= isp))
    else $error("request accepted while disabled or outranked");

  latency_min_a: assert property (@(posedge clk) disable iff (reset) // [RL8]
    acc_mask |-> $past(cand_ok, 8))
    else $error("request accepted before nine clocks");

  latency_max_a: assert property (@(posedge clk) disable iff (reset) // [RL8]
    (cand_ok && pend_cnt_q == LAT_MAX_LAST && !instr_from_ram) |-> acc_mask)
    else $error("request not accepted by sixteen clocks");

  push_order_a: assert property (@(posedge clk) disable iff (reset) // [RL12]
    acc_any |=> ##1 (stack_push && !stack_push_is_pc)
            ##1 (stack_push && stack_push_is_pc && stack_push_data == $past(cpu_pc, 3))
            ##1 vector_load)
    else $error("status, pc and vector out of order");

  enable_clear_a: assert property (@(posedge clk) disable iff (reset) // [RL12]
    acc_any |=> (!sw_q[SW_IE] && irq_busy))
    else $error("enable not cleared on acceptance");

  level_update_a: assert property (@(posedge clk) disable iff (reset) // [RL13]
    (acc_mask && win_lvl != LEVEL_TOP) |=> isp == $past(win_lvl) - 2'd1)
    else $error("in-service level not set to level minus one");

  soft_vector_a: assert property (@(posedge clk) disable iff (reset) // [RL18]
    acc_soft |-> ##4 (vector_load && vector_addr == VEC_SOFT))
    else $error("break did not vector to fixed entry");

  break_uncond_a: assert property (@(posedge clk) disable iff (reset) // [RL17]
    (break_instruction && state_q == ST_IDLE) |-> acc_soft)
    else $error("break not taken at once");

  edge_sets_a: assert property (@(posedge clk) disable iff (reset) // [RL23]
    (eif.edge_hit != 8'h00) |=> ((req_q & $past(eif.edge_hit)) == $past(eif.edge_hit)))
    else $error("detected edge did not set request flag");

endmodule

// ==== bench/ieack_seq_model.sv ====
// sequencer, stack and program counter model on the far side of the block
`timescale 1ns/100ps
module ieack_seq_model
  import ieack_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // pace chosen by the bench
  input  wire logic              slow,
  // block side
  input  wire logic              stack_push,
  input  wire logic              stack_push_is_pc,
  input  wire logic [ADDR_W-1:0] stack_push_data,
  input  wire logic              vector_load,
  input  wire logic [ADDR_W-1:0] vector_addr,
  output logic                   instr_boundary,
  output logic      [ADDR_W-1:0] cpu_pc,
  // stack contents seen by the bench
  output logic      [7:0]        last_status,
  output logic      [ADDR_W-1:0] last_pc,
  output logic                   order_ok
);
  logic status_seen;
  ////////////////////////////////////////
  // a slow sequencer never offers a boundary, so the block must meet its own deadline
  assign instr_boundary = !slow;
  ////////////////////////////////////////
  // stack takes status then pc; pc jumps to the loaded vector
  always @(posedge clk) begin
    if (reset) begin
      cpu_pc      <= 20'h00100;
      status_seen <= 1'b0;
      order_ok    <= 1'b0;
    end else begin
      if (stack_push && !stack_push_is_pc) begin
        last_status <= stack_push_data[7:0];
        status_seen <= 1'b1;
        order_ok    <= 1'b0;
      end
      if (stack_push && stack_push_is_pc) begin
        last_pc     <= stack_push_data;
        order_ok    <= status_seen;
        status_seen <= 1'b0;
      end
      if (vector_load) cpu_pc <= vector_addr;
    end
  end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the interrupt edge and acknowledge block
`timescale 1ns/100ps
module testbench;
  import ieack_pkg::*;
  localparam int OP_BRK = 0, OP_SET = 1, OP_CLR = 2, OP_PUSH = 3;
  localparam int OP_POP = 4, OP_MASKABLE_RETURN_INSTR = 5, OP_SOFT_IRQ_RETURN_INSTR = 6;
  logic              clk, reset, slow, rd_s, wr_s, bit_op, busy, push, push_pc, vload;
  logic              gie, ook, bnd, ram;
  logic [N_EXT-1:0]  pins, mask, pr_lo, pr_hi, rq_clr, rq, req;
  logic [ADDR_W-1:0] addr, pc, push_d, vaddr, lpc;
  logic [SEL_W-1:0]  sel;
  logic [7:0]        wdata, rdata, pop_d, sw, lst, d, s0;
  logic [6:0]        op;
  int                err_total, num_checks, cyc, seed, k, w;

  ieack_top i_dut (.clk(clk), .reset(reset), .ext_irq_input(pins), .mask_flag(mask),
    .priority_bit_lo(pr_lo), .priority_bit_hi(pr_hi), .request_clear(rq_clr),
    .request_flag(rq), .sfr_addr(addr), .sfr_rd(rd_s), .sfr_wr(wr_s), .sfr_bit_op(bit_op),
    .sfr_bit_sel(sel), .sfr_wdata(wdata), .sfr_rdata(rdata), .instr_boundary(bnd),
    .instr_from_ram(ram), .break_instruction(op[OP_BRK]), .set_enable_instr(op[OP_SET]),
    .clear_enable_instr(op[OP_CLR]), .push_status_instr(op[OP_PUSH]),
    .pop_status_instr(op[OP_POP]), .maskable_return_instr(op[OP_MASKABLE_RETURN_INSTR]),
    .soft_irq_return_instr(op[OP_SOFT_IRQ_RETURN_INSTR]), .stack_pop_data(pop_d), .cpu_pc(pc),
    .irq_busy(busy), .stack_push(push), .stack_push_is_pc(push_pc),
    .stack_push_data(push_d), .vector_load(vload), .vector_addr(vaddr),
    .status_word(sw), .global_irq_enable(gie));

  ieack_seq_model i_seq (.clk(clk), .reset(reset), .slow(slow), .stack_push(push),
    .stack_push_is_pc(push_pc), .stack_push_data(push_d), .vector_load(vload),
    .vector_addr(vaddr), .instr_boundary(bnd), .cpu_pc(pc), .last_status(lst),
    .last_pc(lpc), .order_ok(ook));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [ADDR_W-1:0] got, logic [ADDR_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] v, logic b, int s);
    addr = a;
    wdata = v;
    bit_op = b;
    sel = SEL_W'(s);
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    bit_op = 1'b0;
    tick(1);
  endtask
  task automatic rchk(logic [ADDR_W-1:0] a, logic [7:0] exp, string nm);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    rd_s = 1'b0;
    chk(nm, 20'(rdata), 20'(exp));
    tick(1);
  endtask
  task automatic instr(int n, logic [7:0] pd);
    op[n] = 1'b1;
    pop_d = pd;
    tick(1);
    op = '0;
  endtask
  task automatic clr();
    rq_clr = '1;
    tick(1);
    rq_clr = '0;
  endtask
  // lowest level wins; scanning downwards with <= lets the lowest index take ties
  function automatic int winner(logic [7:0] r, logic [7:0] m, logic [7:0] lo, logic [7:0] hi);
    int b;
    b = -1;
    for (int i = N_EXT - 1; i >= 0; i--)
      if (r[i] && !m[i] && (b < 0 || {hi[i], lo[i]} <= {hi[b], lo[b]})) b = i;
    return b;
  endfunction
  // idx below zero means the break path, where the in-service level stays put
  task automatic expect_ack(int idx, logic [7:0] pre, logic [1:0] lvl);
    int n;
    logic [ADDR_W-1:0] pc0;
    logic [1:0] isp;
    n = 0;
    pc0 = pc;
    isp = idx < 0 ? pre[2:1] : (lvl == 2'h0 ? 2'h0 : lvl - 2'h1);
    while (busy !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (idx >= 0) chk("latency in bounds", 20'(n >= 9 && n <= 16), 20'h1);
    while (vload !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("vector", vaddr, idx < 0 ? VEC_SOFT : VEC_EXT_BASE + 20'(2 * idx));
    tick(1);
    chk("saved status", 20'(lst), 20'(pre));
    chk("saved pc", lpc, pc0);
    chk("push order", 20'(ook), 20'h1);
    chk("status after", 20'(sw), 20'({1'b0, pre[6:3], isp, pre[0]}));
  endtask
  ////////////////////////////////////////
  initial begin
    seed = 32'hEC3B4C19;
    {ram, slow, pins, rq_clr, rd_s, wr_s, bit_op, sel, wdata, addr, pop_d, op} = '0;
    {mask, pr_lo, pr_hi} = '1;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rchk(ADDR_RISE_EN, RISE_EN_RST, "rise enable reset");
    rchk(ADDR_FALL_EN, FALL_EN_RST, "fall enable reset");
    chk("status reset", 20'(sw), 20'(STATUS_RST));
    d = 8'($random(seed));
    wr(ADDR_FALL_EN, d, 1'b0, 0);
    rchk(ADDR_FALL_EN, d, "fall byte write");
    rchk(20'h12345, 8'h00, "unmapped read");
    for (int m = 0; m < 4; m++) begin
      k = $unsigned($random(seed)) % N_EXT;
      wr(ADDR_RISE_EN, 8'h00, 1'b0, 0);
      wr(ADDR_FALL_EN, 8'h00, 1'b0, 0);
      wr(ADDR_RISE_EN, {7'h0, m[1]}, 1'b1, k);
      wr(ADDR_FALL_EN, {7'h0, m[0]}, 1'b1, k);
      rchk(ADDR_RISE_EN, 8'(m[1]) << k, "rise bit write");
      pins[k] = 1'b1;
      tick(4);
      chk("rising flags", 20'(rq), 20'(8'(m[1]) << k));
      clr();
      pins[k] = 1'b0;
      tick(4);
      chk("falling flags", 20'(rq), 20'(8'(m[0]) << k));
      clr();
    end
    // falling edges off and rising edges on for every pin, so the pin levels driven below raise requests
    wr(ADDR_FALL_EN, 8'h00, 1'b0, 0);
    wr(ADDR_RISE_EN, 8'hFF, 1'b0, 0);
    for (int i = 0; i < 6; i++) begin
      req = 8'($random(seed)) | 8'h01;
      pr_lo = 8'($random(seed));
      pr_hi = 8'($random(seed));
      pins = req;
      tick(4);
      instr(OP_POP, 8'h86);
      chk("status pop", 20'(sw), 20'h86);
      tick(20);
      chk("all masked idle", 20'(busy), 20'h0);
      chk("flags held", 20'(rq), 20'(req));
      slow = i[0];
      mask = 8'($random(seed)) & ~(req & (~req + 8'h01));
      w = winner(req, mask, pr_lo, pr_hi);
      expect_ack(w, 8'h86, {pr_hi[w], pr_lo[w]});
      chk("others pending", 20'(rq), 20'(req & ~(8'h01 << w)));
      pins = '0;
      mask = '1;
      slow = 1'b0;
      clr();
    end
    pr_hi = 8'h08;
    pr_lo = 8'h00;
    pins = 8'h08;
    tick(4);
    mask = 8'hF7;
    tick(20);
    chk("enable clear holds off", 20'(busy), 20'h0);
    instr(OP_POP, 8'h82);
    tick(20);
    chk("level two blocked", 20'(busy), 20'h0);
    // code running from ram with no boundary: the upper bound must not force entry
    {ram, slow} = 2'b11;
    instr(OP_MASKABLE_RETURN_INSTR, 8'h86);
    chk("return restore", 20'(sw), 20'h86);
    tick(20);
    chk("ram stretches wait", 20'(busy), 20'h0);
    instr(OP_CLR, 8'h00);
    {ram, slow} = 2'b00;
    tick(1);
    instr(OP_SET, 8'h00);
    expect_ack(3, 8'h86, 2'h2);
    mask = '1;
    s0 = sw;
    instr(OP_BRK, 8'h00);
    expect_ack(-1, s0, 2'h0);
    // a break handler leaves by the soft return only
    instr(OP_SOFT_IRQ_RETURN_INSTR, 8'h06);
    chk("soft return restore", 20'(sw), 20'h06);
    tick(1);
    instr(OP_PUSH, 8'h00);
    tick(2);
    chk("status pushed", 20'(lst), 20'h06);
    instr(OP_SET, 8'h00);
    chk("set enable", 20'(gie), 20'h1);
    tick(1);
    instr(OP_CLR, 8'h00);
    chk("clear enable", 20'(gie), 20'h0);
    wr(ADDR_STATUS, 8'h84, 1'b0, 0);
    rchk(ADDR_STATUS, 8'h84, "status byte");
    wr(ADDR_STATUS, 8'h00, 1'b1, SW_IE);
    chk("status bit write", 20'(sw), 20'h04);
    end_sim();
  end
endmodule
